/* File: smf_pkg.sv */
// shared constants for the spi memory command front end
package smf_pkg;
   localparam logic [7:0] OP_WRITE_ENABLE_CMD_C = 8'h06;
   localparam logic [7:0] OP_WRITE_DISABLE_CMD_C = 8'h04;
   localparam logic [7:0] OP_STATUS_READ_CMD_C = 8'h05;
   localparam logic [7:0] OP_STATUS_WRITE_CMD_C = 8'h01;
   localparam logic [7:0] OP_READ_C = 8'h03;
   localparam logic [7:0] OP_FRD_C  = 8'h0B;
   localparam logic [7:0] OP_WRITE_C = 8'h02;
   localparam logic [7:0] OP_SLEEP_C = 8'hB9;
   localparam logic [7:0] OP_ID_C   = 8'h9F;
   localparam int         WEF_BIT_C = 1;
   localparam int         ADDR_W_C  = 14;
   localparam logic [2:0] BIT_LAST_C = 3'h7;
   localparam logic [4:0] ADDR_END_C = 5'h17;
   localparam logic [4:0] CNT_SAT_C  = 5'h1F;
   localparam logic [2:0] DIV_HALF_C = 3'h3;
   localparam int         ADDR_HI_C = 23;
   localparam int         ADDR_LO_C = 8;
endpackage

/* File: smf_if.sv */
// spi link between the master and the memory front end
`timescale 1ns/1ps
interface smf_if;
   logic cs_n;
   logic sck;
   logic si;
   logic so;
   logic so_oe;
   modport dev (input cs_n, input sck, input si, output so, output so_oe);
   modport mst (output cs_n, output sck, output si, input so, input so_oe);
endinterface

/* File: smf_dev.sv */
// spi slave command front end with write enable latch and status byte
`timescale 1ns/1ps
module smf_dev
(
   input  wire logic                  i_ref_clk,   // system clock
   input  wire logic                  i_rst_n,     // async reset, low
   smf_if.dev                         spi,         // spi pins
   output logic                       o_wef,       // write enable flag
   output logic [smf_pkg::ADDR_W_C-1:0] o_addr,    // captured address
   output logic [7:0]                 o_opcode,    // last opcode taken
   output logic                       o_mode3,     // mode of transfer
   output logic                       o_bad_op     // last opcode unknown
);
   typedef enum logic [3:0]
   {
      ST_IDLE = 4'h1,
      ST_OP   = 4'h2,
      ST_ARG  = 4'h4,
      ST_DEAD = 4'h8
   } smf_state_e;

   smf_state_e state_reg;
   logic [2:0] cs_sync_reg, sck_sync_reg;
   logic [1:0] si_sync_reg;
   logic       cs_n, sck, sck_prev_reg;
   logic       armed_reg;
   logic [4:0] cnt_reg;
   logic [7:0] sh_reg, tx_reg;
   logic [15:0] addr_sh_reg;
   logic       tx_on_reg;
   logic       so_reg, so_oe_reg;
   logic       cs_fall, cs_rise, sck_rise, sck_fall, take;
   logic [7:0] op_in;
   logic       known;

   // two flops before any logic reads the pins
   always_ff @(posedge i_ref_clk or negedge i_rst_n)
      if (!i_rst_n)
      begin
         cs_sync_reg  <= 3'h7;
         sck_sync_reg <= 3'h0;
         si_sync_reg  <= 2'h0;
      end
      else
      begin
         cs_sync_reg  <= {cs_sync_reg[1:0], spi.cs_n};
         sck_sync_reg <= {sck_sync_reg[1:0], spi.sck};
         si_sync_reg  <= {si_sync_reg[0], spi.si};
      end

   assign cs_n     = cs_sync_reg[1];
   assign sck      = sck_sync_reg[1];
   assign cs_fall  = cs_sync_reg[2] & ~cs_sync_reg[1];
   assign cs_rise  = ~cs_sync_reg[2] & cs_sync_reg[1];
   assign sck_rise = ~sck_sync_reg[2] & sck_sync_reg[1];
   assign sck_fall = sck_sync_reg[2] & ~sck_sync_reg[1];
   // rising edges count only once armed, which mode 3 delays
   assign take     = ~cs_n & sck_rise & armed_reg;
   assign op_in    = {sh_reg[6:0], si_sync_reg[1]};

   always_comb
   begin
      case (op_in)
         smf_pkg::OP_WRITE_ENABLE_CMD_C, smf_pkg::OP_WRITE_DISABLE_CMD_C,
         smf_pkg::OP_STATUS_READ_CMD_C, smf_pkg::OP_STATUS_WRITE_CMD_C,
         smf_pkg::OP_READ_C, smf_pkg::OP_FRD_C,
         smf_pkg::OP_WRITE_C, smf_pkg::OP_SLEEP_C,
         smf_pkg::OP_ID_C: known = 1'b1;
         default:          known = 1'b0;
      endcase
   end

   // mode chosen from clock level when select falls
   always_ff @(posedge i_ref_clk or negedge i_rst_n)
      if (!i_rst_n)
      begin
         o_mode3   <= 1'b0;
         armed_reg <= 1'b0;
      end
      else if (cs_fall)
      begin
         o_mode3   <= sck;
         armed_reg <= ~sck;
      end
      else if (!cs_n && sck_fall)
         armed_reg <= 1'b1;

   always_ff @(posedge i_ref_clk or negedge i_rst_n)
      if (!i_rst_n)
      begin
         state_reg <= ST_IDLE;
         cnt_reg   <= 5'h0;
         sh_reg    <= 8'h0;
         o_opcode  <= 8'h0;
         o_bad_op  <= 1'b0;
      end
      else if (cs_n)
         state_reg <= ST_IDLE;
      else if (cs_fall || state_reg == ST_IDLE)
      begin
         state_reg <= ST_OP;
         cnt_reg   <= 5'h0;
      end
      else if (take)
      begin
         sh_reg <= op_in;
         if (cnt_reg != smf_pkg::CNT_SAT_C)
            cnt_reg <= cnt_reg + 5'h1;
         case (state_reg)
            ST_OP:
               if (cnt_reg[2:0] == smf_pkg::BIT_LAST_C)
               begin
                  o_opcode  <= op_in;
                  o_bad_op  <= ~known;
                  state_reg <= known ? ST_ARG : ST_DEAD;
               end
            ST_ARG:  state_reg <= ST_ARG;
            ST_DEAD: state_reg <= ST_DEAD;
            default: state_reg <= ST_IDLE;
         endcase
      end

   // address follows the opcode for every known opcode
   always_ff @(posedge i_ref_clk or negedge i_rst_n)
      if (!i_rst_n)
      begin
         addr_sh_reg <= 16'h0;
         o_addr      <= '0;
      end
      else if (take && state_reg == ST_ARG && cnt_reg <= smf_pkg::ADDR_END_C)
      begin
         addr_sh_reg <= {addr_sh_reg[14:0], si_sync_reg[1]};
         if (cnt_reg == smf_pkg::ADDR_END_C)
            o_addr <= {addr_sh_reg[12:0], si_sync_reg[1]};
      end

   always_ff @(posedge i_ref_clk or negedge i_rst_n)
      if (!i_rst_n)
         o_wef <= 1'b0;
      else if (take && state_reg == ST_OP &&
               cnt_reg[2:0] == smf_pkg::BIT_LAST_C &&
               op_in == smf_pkg::OP_WRITE_ENABLE_CMD_C)
         o_wef <= 1'b1;
      else if (cs_rise && state_reg != ST_DEAD &&
               (o_opcode == smf_pkg::OP_WRITE_DISABLE_CMD_C ||
                o_opcode == smf_pkg::OP_STATUS_WRITE_CMD_C ||
                o_opcode == smf_pkg::OP_WRITE_C))
         o_wef <= 1'b0;

   // status byte: only the latch flag is held here
   always_ff @(posedge i_ref_clk or negedge i_rst_n)
      if (!i_rst_n)
      begin
         tx_reg    <= 8'h0;
         tx_on_reg <= 1'b0;
         so_reg    <= 1'b0;
         so_oe_reg <= 1'b0;
      end
      else if (cs_n)
      begin
         tx_on_reg <= 1'b0;
         so_oe_reg <= 1'b0;
      end
      else if (take && state_reg == ST_OP &&
               cnt_reg[2:0] == smf_pkg::BIT_LAST_C)
      begin
         tx_on_reg <= (op_in == smf_pkg::OP_STATUS_READ_CMD_C);
         tx_reg    <= 8'h0;
         tx_reg[smf_pkg::WEF_BIT_C] <= o_wef;
      end
      else if (sck_fall && tx_on_reg)
      begin
         // stop driving once the status byte has gone out
         if (cnt_reg > 5'h8 && cnt_reg[2:0] == 3'h0)
         begin
            tx_on_reg <= 1'b0;
            so_oe_reg <= 1'b0;
         end
         else
         begin
            so_reg    <= tx_reg[7];
            tx_reg    <= {tx_reg[6:0], 1'b0};
            so_oe_reg <= 1'b1;
         end
      end

   assign spi.so    = so_reg;
   assign spi.so_oe = so_oe_reg;
endmodule

/* File: smf_mst.sv */
// spi master end: sends one command frame per request
`timescale 1ns/1ps
module smf_mst
(
   input  wire logic         i_ref_clk,   // system clock
   input  wire logic         i_rst_n,     // async reset, low
   smf_if.mst                spi,         // spi pins
   input  wire logic         i_start,     // start frame pulse
   input  wire logic         i_mode3,     // idle clock high
   input  wire logic [1:0]   i_nbytes,    // bytes after opcode 0..3
   input  wire logic [31:0]  i_tx,        // opcode first, msb aligned
   output logic              o_busy,      // frame in progress
   output logic              o_done,      // frame ended pulse
   output logic [7:0]        o_rx         // last byte received
);
   logic [2:0]  div_reg;
   logic [5:0]  bits_reg;
   logic [31:0] sh_reg;
   logic        so_sync_reg, so_s2_reg;
   logic        first_reg;

   always_ff @(posedge i_ref_clk or negedge i_rst_n)
      if (!i_rst_n)
      begin
         so_sync_reg <= 1'b0;
         so_s2_reg   <= 1'b0;
      end
      else
      begin
         so_sync_reg <= spi.so;
         so_s2_reg   <= so_sync_reg;
      end

   // sck comes from a divider; data changes low, sampled high
   always_ff @(posedge i_ref_clk or negedge i_rst_n)
      if (!i_rst_n)
      begin
         spi.cs_n <= 1'b1;
         spi.sck  <= 1'b0;
         spi.si   <= 1'b0;
         o_busy   <= 1'b0;
         o_done   <= 1'b0;
         o_rx     <= 8'h0;
         div_reg  <= 3'h0;
         bits_reg <= 6'h0;
         sh_reg   <= 32'h0;
         first_reg <= 1'b0;
      end
      else
      begin
         o_done <= 1'b0;
         if (!o_busy)
         begin
            spi.sck <= i_mode3;
            if (i_start)
            begin
               o_busy   <= 1'b1;
               spi.cs_n <= 1'b0;
               sh_reg   <= i_tx;
               spi.si   <= i_tx[31];
               bits_reg <= {i_nbytes + 3'h1, 3'h0};
               div_reg  <= 3'h0;
               first_reg <= i_mode3;
            end
         end
         else if (div_reg != smf_pkg::DIV_HALF_C)
            div_reg <= div_reg + 3'h1;
         else
         begin
            div_reg <= 3'h0;
            if (bits_reg == 6'h0)
            begin
               spi.cs_n <= 1'b1;
               spi.sck  <= i_mode3;
               o_busy   <= 1'b0;
               o_done   <= 1'b1;
            end
            else if (!spi.sck)
               spi.sck <= 1'b1;
            else if (spi.cs_n == 1'b0)
            begin
               spi.sck  <= 1'b0;
               // mode 3 opening fall only leaves the idle level: the
               // first bit is still unsampled, so nothing shifts yet
               if (first_reg)
                  first_reg <= 1'b0;
               else
               begin
                  o_rx     <= {o_rx[6:0], so_s2_reg};
                  sh_reg   <= {sh_reg[30:0], 1'b0};
                  spi.si   <= sh_reg[30];
                  bits_reg <= bits_reg - 6'h1;
               end
            end
         end
      end
endmodule

/* File: smf_props.sv */
// assertions on the spi link between master and memory front end
`timescale 1ns/1ps
module smf_props
(
   input  wire logic i_ref_clk, // system clock
   input  wire logic i_rst_n,   // async reset, low
   input  wire logic cs_n,      // select, low
   input  wire logic sck,       // serial clock
   input  wire logic si,        // master to device
   input  wire logic so,        // device to master
   input  wire logic so_oe      // device drives so
);
   logic       sck_q;
   logic       cs_q;
   logic       rise;
   logic       write_enable_flag;
   logic       known;
   logic [4:0] rises;
   logic [4:0] nrise;
   logic [7:0] shift;
   logic [7:0] op_q;
   default clocking cb @(posedge i_ref_clk);
   endclocking
   default disable iff (!i_rst_n);
   assign rise  = sck & ~sck_q;
   assign nrise = rises + {4'h0, rise};
   assign known = op_q inside {8'h06, 8'h04, 8'h05, 8'h01, 8'h03, 8'h0B,
                               8'h02, 8'hB9, 8'h9F};
   // mode 3 needs no special case: idle-high clock gives no rise at select
   always_ff @(posedge i_ref_clk or negedge i_rst_n)
      if (!i_rst_n)
      begin
         sck_q <= 1'b0;
         cs_q  <= 1'b1;
         rises <= 5'h00;
         shift <= 8'h00;
         op_q  <= 8'h00;
      end
      else
      begin
         sck_q <= sck;
         cs_q  <= cs_n;
         if (cs_n)
            rises <= 5'h00;
         else if (rise && rises != 5'h1F)
            rises <= nrise;
         if (rise)
            shift <= {shift[6:0], si};
         if (rise && rises == 5'h07 && !cs_n)
            op_q <= {shift[6:0], si};
      end
   // expected latch, judged only at status reads in later frames
   always_ff @(posedge i_ref_clk or negedge i_rst_n)
      if (!i_rst_n)
         write_enable_flag <= 1'b0;
      else if (cs_n && !cs_q && rises >= 5'h08)
         write_enable_flag <= (op_q == 8'h06) ? 1'b1 :
                (op_q inside {8'h04, 8'h01, 8'h02}) ? 1'b0 : write_enable_flag;
   idle_quiet_a:
      assert property (cs_n [*6] |-> !so_oe)
         else $error("so driven while deselected");
   fall_shift_a:
      assert property (so_oe && $past(so_oe) && $changed(so) |-> !sck)
         else $error("so changed while clock high");
   opcode_silent_a:
      assert property (!cs_n && nrise < 5'h08 |-> !so_oe)
         else $error("so driven during opcode");
   bad_quiet_a:
      assert property (!cs_n && rises >= 5'h08 && !known |-> !so_oe)
         else $error("so driven after unknown opcode");
   status_drive_a:
      assert property (!cs_n && rises == 5'h08 && $past(rises) == 5'h07
                       && op_q == 8'h05 |-> ##[1:12] so_oe)
         else $error("status byte not driven");
   status_zero_a:
      assert property (!cs_n && so_oe && sck && op_q == 8'h05
                       && nrise != 5'h0F |-> !so)
         else $error("status spare bit not zero");
   status_flag_a:
      assert property (!cs_n && so_oe && sck && op_q == 8'h05
                       && nrise == 5'h0F |-> so == write_enable_flag)
         else $error("status flag bit wrong");
   status_end_a:
      assert property (!cs_n && op_q == 8'h05 && rises >= 5'h11 |-> !so_oe)
         else $error("so driven beyond status byte");
endmodule

/* File: spi_memory_command_front_end_bench.sv */
// self-checking bench: master and front end joined by the spi link
`timescale 1ns/1ps
module spi_memory_command_front_end_bench;
   logic        clk;
   logic        rst_n;
   logic        start;
   logic        mode3;
   logic        busy;
   logic        done;
   logic        wef;
   logic        mode_seen;
   logic        bad_op;
   logic [1:0]  nbytes;
   logic [31:0] tx;
   logic [7:0]  rx;
   logic [13:0] addr;
   logic [7:0]  opcode;
   int          bad_count;
   int          checks_done;
   smf_if smf_if_i ();
   smf_dev smf_dev_i (.i_ref_clk(clk), .i_rst_n(rst_n), .spi(smf_if_i.dev),
      .o_wef(wef), .o_addr(addr), .o_opcode(opcode), .o_mode3(mode_seen),
      .o_bad_op(bad_op));
   smf_mst smf_mst_i (.i_ref_clk(clk), .i_rst_n(rst_n), .spi(smf_if_i.mst),
      .i_start(start), .i_mode3(mode3), .i_nbytes(nbytes), .i_tx(tx),
      .o_busy(busy), .o_done(done), .o_rx(rx));
   smf_props smf_props_i (.i_ref_clk(clk), .i_rst_n(rst_n),
      .cs_n(smf_if_i.cs_n), .sck(smf_if_i.sck), .si(smf_if_i.si),
      .so(smf_if_i.so), .so_oe(smf_if_i.so_oe));
   initial
   begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end
   task automatic chk(input string name, input logic [15:0] exp,
                      input logic [15:0] got);
      checks_done++;
      if (got !== exp)
      begin
         bad_count++;
         $display("unexpected %s: expected %h seen %h", name, exp, got);
      end
   endtask
   task automatic test_done;
      $display("checks %0d mismatches %0d", checks_done, bad_count);
      if (bad_count == 0 && checks_done > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   // idle clock level is settled before select so the mode is unambiguous
   task automatic frame(input logic m3, input logic [1:0] n,
                        input logic [31:0] d);
      int k;
      @(posedge clk);
      mode3 <= m3;
      repeat (6) @(posedge clk);
      start  <= 1'b1;
      nbytes <= n;
      tx     <= d;
      @(posedge clk);
      start <= 1'b0;
      @(negedge clk);
      chk("busy", 16'h0001, 16'(busy));
      k = 0;
      while (done !== 1'b1 && k < 400)
      begin
         @(negedge clk);
         k++;
      end
      chk("frame done", 16'h0001, 16'(done));
      chk("busy", 16'h0000, 16'(busy));
      repeat (10) @(posedge clk);
   endtask
   task automatic status(input logic m3, input logic [7:0] exp);
      frame(m3, 2'h1, {smf_pkg::OP_STATUS_READ_CMD_C, 24'h0});
      chk("status byte", 16'(exp), 16'(rx));
      chk("mode", 16'(m3), 16'(mode_seen));
   endtask
   task automatic t_reset;
      chk("flag", 16'h0000, 16'(wef));
      chk("so enable", 16'h0000, 16'(smf_if_i.so_oe));
      status(1'b0, 8'h00);
      frame(1'b1, 2'h1, {smf_pkg::OP_STATUS_WRITE_CMD_C, 8'hFF, 16'h0});
      chk("flag", 16'h0000, 16'(wef));
   endtask
   task automatic t_clear;
      logic [7:0] ops [3];
      ops = '{smf_pkg::OP_WRITE_DISABLE_CMD_C, smf_pkg::OP_STATUS_WRITE_CMD_C, smf_pkg::OP_WRITE_C};
      for (int i = 0; i < 3; i++)
      begin
         frame(1'b0, 2'h0, {smf_pkg::OP_WRITE_ENABLE_CMD_C, 24'h0});
         chk("flag", 16'h0001, 16'(wef));
         status(1'b1, 8'h02);
         frame(1'b0, 2'h3, {ops[i], 8'hC1, 8'h23, 8'h5A});
         chk("flag", 16'h0000, 16'(wef));
         status(1'b0, 8'h00);
      end
      chk("address", 16'h0123, 16'(addr));
   endtask
   task automatic t_keep;
      logic [7:0] ops [5];
      ops = '{smf_pkg::OP_READ_C, smf_pkg::OP_FRD_C, smf_pkg::OP_ID_C,
              smf_pkg::OP_STATUS_READ_CMD_C, smf_pkg::OP_SLEEP_C};
      frame(1'b1, 2'h0, {smf_pkg::OP_WRITE_ENABLE_CMD_C, 24'h0});
      for (int i = 0; i < 5; i++)
      begin
         frame(1'b0, 2'h2, {ops[i], 8'h00, 8'h45, 8'h00});
         chk("opcode", 16'(ops[i]), 16'(opcode));
         chk("bad opcode", 16'h0000, 16'(bad_op));
         chk("flag", 16'h0001, 16'(wef));
         if (i == 0)
            chk("address", 16'h0045, 16'(addr));
      end
   endtask
   task automatic t_bad;
      frame(1'b0, 2'h0, {smf_pkg::OP_WRITE_DISABLE_CMD_C, 24'h0});
      frame(1'b0, 2'h3, {8'h07, smf_pkg::OP_WRITE_ENABLE_CMD_C, 16'h0});
      chk("bad opcode", 16'h0001, 16'(bad_op));
      chk("flag", 16'h0000, 16'(wef));
      frame(1'b1, 2'h0, {smf_pkg::OP_WRITE_ENABLE_CMD_C, 24'h0});
      chk("bad opcode", 16'h0000, 16'(bad_op));
      chk("flag", 16'h0001, 16'(wef));
   endtask
   initial
   begin
      bad_count = 0;
      checks_done = 0;
      rst_n = 1'b0;
      start = 1'b0;
      mode3 = 1'b0;
      nbytes = 2'h0;
      tx = 32'h0;
      repeat (3) @(posedge clk);
      rst_n <= 1'b1;
      repeat (5) @(posedge clk);
      t_reset;
      t_clear;
      t_keep;
      t_bad;
      test_done;
   end
   // 23 frames of at most 300 cycles each, with wide margin
   initial
   begin
      #400000;
      bad_count++;
      test_done;
   end
endmodule
